// ==== logic/acv_control.sv ====
// system control block: i/o ports, memory decode, character video, watchdog
// assumes io and memory strobes are one-cycle pulses on clk; buttons, dips
// and the game interrupt line are asynchronous and are synchronised here
// Function
// - decode boot rom, work ram, backup ram, video ram, cart bios, protection
// - port 0 returns select, enter, reset buttons, zero bit 4, coin, service
// - port 0 bit 3 is a latched game interrupt flag held until cleared
// - ports 1 and 2 return the two dip banks
// - reading port 3 clears the interrupt flag
// - output ports latch data bit 0 only
// - port 0 gives video ram to processor at 0, video at 1; 0 blanks
// - port 1 enables player controls
// - port 2 enables game picture output, port 3 game sound
// - port 4 holds game processor in reset while 0
// - port 5 halts game processor while 0 without reset
// - port 6 routes monitor to character video at 0, game picture at 1
// - port 0x0A holds game video processor in reset while 0
// - ports 0x0B to 0x0E form slot number selecting cart bios and protection
// - port 0x0F enables upper kilobyte of backup ram
// - processor writes video ram only while port 0 bit 0 is 0
// - 32 by 28 grid, first visible row at video ram offset 0x080
// - cell is two bytes: eleven bit code, five bit color
// - 60 hz refresh, nmi each vertical blank while enabled
// - enabled watchdog resets the processor after 8 refreshes
// - a 0 to 1 write on port 9 restarts the watchdog count
`timescale 1ns/10ps
module acv_control
  import acv_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [15:0] memAddr,
  input wire logic memWr,
  input wire logic [7:0] memWrData,
  input wire logic [7:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic btnSelect,
  input wire logic btnEnter,
  input wire logic btnReset,
  input wire logic coin2,
  input wire logic btnService,
  input wire logic [7:0] dipBank1,
  input wire logic [7:0] dipBank2,
  input wire logic gameIrqN,
  output logic bootRomSel,
  output logic workRamSel,
  output logic backupRamSel,
  output logic vramSel,
  output logic cartBiosSel,
  output logic protectSel,
  output logic [3:0] slotNumber,
  output logic controlsEnable,
  output logic pictureOutEnable,
  output logic soundOutEnable,
  output logic gameCpuResetN,
  output logic gameCpuRun,
  output logic monitorGameSel,
  output logic pictureResetN,
  output logic cpuNmi,
  output logic cpuResetN,
  output logic pixValid,
  output logic [2:0] pixX,
  output logic [2:0] pixY,
  output logic [10:0] charCode,
  output logic [4:0] charColor
);

  localparam int LINE_CYCLES = FRAME_CYCLES / LINES_PER_FRAME;
  localparam logic [8:0] LAST_LINE = 9'(LINES_PER_FRAME - 1);
  localparam logic [23:0] LAST_CYC = 24'(LINE_CYCLES - 1);
  localparam logic [7:0] WD_HOLD_LAST = 8'(WD_HOLD_CYCLES - 1);

  // input synchronisers
  logic [21:0] sync1_q;
  logic [21:0] sync2_q;
  wire [21:0] rawIn = {gameIrqN, dipBank2, dipBank1, btnService, coin2,
                       btnReset, btnEnter, btnSelect};
  wire sBtnSel = sync2_q[0];
  wire sBtnEnt = sync2_q[1];
  wire sBtnRst = sync2_q[2];
  wire sCoin2 = sync2_q[3];
  wire sService = sync2_q[4];
  wire [7:0] sDip1 = sync2_q[12:5];
  wire [7:0] sDip2 = sync2_q[20:13];
  wire sIrqN = sync2_q[21];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 22'h200000;
      sync2_q <= 22'h200000;
    end else if (ce) begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end

  // port strobes
  wire portSpace = (ioAddr[7:4] == 4'h0);
  wire portWr = ioWr & portSpace;
  wire [3:0] portIdx = ioAddr[3:0];

  // output port latches
  logic [15:0] ports_q;
  logic [15:0] ports_d;

  always_comb begin
    ports_d = ports_q;
    if (portWr) begin
      ports_d[portIdx] = ioWrData[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ports_q <= OUT_PORTS_RESET;
    end else if (ce) begin
      ports_q <= ports_d;
    end
  end

  wire vramByVideo = ports_q[OUT_CHARACTER_VIDEO_RAM_OWNER];
  assign controlsEnable = ports_q[OUT_CTRL_EN];
  assign pictureOutEnable = ports_q[OUT_PIC_EN];
  assign soundOutEnable = ports_q[OUT_SOUND_EN];
  assign gameCpuResetN = ports_q[OUT_GCPU_RST];
  assign gameCpuRun = ports_q[OUT_GCPU_RUN];
  assign monitorGameSel = ports_q[OUT_MON_SEL];
  assign pictureResetN = ports_q[OUT_PIC_RST];
  assign slotNumber = ports_q[OUT_SLOT_LSB +: 4];
  wire nmiEnable = ports_q[OUT_NMI_EN];
  wire bramHiEnable = ports_q[OUT_BRAM_HI];
  wire wdBit = ports_q[OUT_WDOG];

  // memory decode
  wire slotValid = (slotNumber < SLOT_COUNT);
  wire bramHit = addrHit(memAddr, MEM_BRAM_BASE, MEM_2K_SIZE);
  wire bramHiHit = addrHit(memAddr, MEM_BRAM_HI_BASE, MEM_1K_SIZE);
  assign bootRomSel = addrHit(memAddr, MEM_BOOT_BASE, MEM_BOOT_SIZE);
  assign workRamSel = addrHit(memAddr, MEM_WRAM_BASE, MEM_2K_SIZE);
  assign backupRamSel = bramHit & (~bramHiHit | bramHiEnable);
  assign vramSel = addrHit(memAddr, MEM_CHARACTER_VIDEO_RAM_BASE, MEM_2K_SIZE) & ~vramByVideo;
  assign cartBiosSel = addrHit(memAddr, MEM_CART_BASE, MEM_8K_SIZE) & slotValid;
  assign protectSel = addrHit(memAddr, MEM_PROT_BASE, MEM_8K_SIZE) & slotValid;

  // interrupt detect flag, set wins over clear
  logic irqFlag_q;
  wire irqClear = ioRd & (ioAddr == IN_IRQ_CLR);
  wire irqFlag_d = ~sIrqN | (irqFlag_q & ~irqClear);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqFlag_q <= 1'b0;
    end else if (ce) begin
      irqFlag_q <= irqFlag_d;
    end
  end

  // read port mux
  wire [7:0] btnByte = {1'b0, sService, sCoin2, 1'b0, irqFlag_q,
                        sBtnRst, sBtnEnt, sBtnSel};
  wire [7:0] rdMux = (ioAddr == IN_BUTTONS) ? btnByte :
                     (ioAddr == IN_DIP1) ? sDip1 :
                     (ioAddr == IN_DIP2) ? sDip2 :
                     IN_UNMAPPED;
  logic [7:0] rdData_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 8'h00;
    end else if (ce && ioRd) begin
      rdData_q <= rdMux;
    end
  end

  assign ioRdData = rdData_q;

  // character video ram, even and odd bytes of each cell
  logic [7:0] vramLo [0:1023];
  logic [7:0] vramHi [0:1023];
  wire vramWr = memWr & vramSel;
  wire [9:0] cpuWord = memAddr[10:1];

  always_ff @(posedge clk) begin
    if (ce && vramWr) begin
      if (memAddr[0]) begin
        vramHi[cpuWord] <= memWrData;
      end else begin
        vramLo[cpuWord] <= memWrData;
      end
    end
  end

  // raster timing
  logic [23:0] lineCyc_q;
  logic [8:0] line_q;
  wire lineEnd = (lineCyc_q == LAST_CYC);
  wire frameTick = (line_q == VISIBLE_LINES) & (lineCyc_q == 24'h000000);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lineCyc_q <= 24'h000000;
      line_q <= 9'h000;
    end else if (ce) begin
      if (lineEnd) begin
        lineCyc_q <= 24'h000000;
        line_q <= (line_q == LAST_LINE) ? 9'h000 : line_q + 9'h001;
      end else begin
        lineCyc_q <= lineCyc_q + 24'h000001;
      end
    end
  end

  // cell fetch
  wire inSlots = (lineCyc_q[23:12] == 12'h000);
  wire visible = inSlots & (line_q < VISIBLE_LINES) & vramByVideo;
  wire [7:0] pixCol = lineCyc_q[11:4];
  wire [9:0] cellIdx = {line_q[7:3], pixCol[7:3]};
  wire [9:0] fetchWord = CHARACTER_VIDEO_RAM_ROW0_WORD + cellIdx;
  logic [7:0] cellLo_q;
  logic [7:0] cellHi_q;

  always_ff @(posedge clk) begin
    if (ce) begin
      cellLo_q <= vramLo[fetchWord];
      cellHi_q <= vramHi[fetchWord];
    end
  end

  logic pixValid_q;
  logic [2:0] pixX_q;
  logic [2:0] pixY_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pixValid_q <= 1'b0;
      pixX_q <= 3'h0;
      pixY_q <= 3'h0;
    end else if (ce) begin
      pixValid_q <= visible;
      pixX_q <= pixCol[2:0];
      pixY_q <= line_q[2:0];
    end
  end

  assign pixValid = pixValid_q;
  assign pixX = pixX_q;
  assign pixY = pixY_q;
  assign charCode = pixValid_q ? {cellHi_q[2:0], cellLo_q} : 11'h000;
  assign charColor = pixValid_q ? cellHi_q[7:3] : 5'h00;

  // vertical blank nmi
  logic nmi_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nmi_q <= 1'b0;
    end else if (ce) begin
      nmi_q <= frameTick & nmiEnable;
    end
  end

  assign cpuNmi = nmi_q;

  // watchdog
  acv_wd_type wdState_q;
  acv_wd_type wdState_d;
  logic [3:0] wdCount_q;
  logic [3:0] wdCount_d;
  logic [7:0] wdHold_q;
  logic [7:0] wdHold_d;
  wire wdRestart = portWr & (portIdx == OUT_WDOG) & ioWrData[0] & ~wdBit;
  wire wdEnabled = ~wdBit;

  always_comb begin
    wdState_d = wdState_q;
    wdCount_d = wdCount_q;
    wdHold_d = wdHold_q;
    case (wdState_q)
      WD_WATCH: begin
        if (wdRestart) begin
          wdCount_d = 4'h0;
        end else if (wdEnabled && frameTick) begin
          wdCount_d = wdCount_q + 4'h1;
          if (wdCount_q == WD_FRAMES - 4'h1) begin
            wdState_d = WD_FIRE;
            wdHold_d = 8'h00;
          end
        end
      end
      WD_FIRE: begin
        wdHold_d = wdHold_q + 8'h01;
        if (wdHold_q == WD_HOLD_LAST) begin
          wdState_d = WD_WATCH;
          wdCount_d = 4'h0;
        end
      end
      default: begin
        wdState_d = WD_WATCH;
        wdCount_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdState_q <= WD_WATCH;
      wdCount_q <= 4'h0;
      wdHold_q <= 8'h00;
    end else if (ce) begin
      wdState_q <= wdState_d;
      wdCount_q <= wdCount_d;
      wdHold_q <= wdHold_d;
    end
  end

  assign cpuResetN = (wdState_q != WD_FIRE);

endmodule : acv_control

// ==== logic/acv_pkg.sv ====
// constants, port map and memory map for the arcade control block
// assumes a single 100 MHz system clock domain
package acv_pkg;

  localparam int CLK_HZ = 100000000;
  localparam int REFRESH_HZ = 60;
  localparam int FRAME_CYCLES_DEF = CLK_HZ / REFRESH_HZ;
  localparam int LINES_PER_FRAME = 262;
  localparam int WD_HOLD_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_HOLD_CYCLES = (WD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // character grid
  localparam int GRID_COLS = 32;
  localparam int GRID_ROWS = 28;
  localparam logic [8:0] VISIBLE_LINES = 9'h0E0;
  localparam logic [11:0] PIX_SLOTS_END = 12'hFFF;
  localparam logic [9:0] CHARACTER_VIDEO_RAM_ROW0_WORD = 10'h040;
  localparam logic [10:0] CHARACTER_VIDEO_RAM_ROW0_BYTE = 11'h080;

  // write ports, bit 0 only
  localparam logic [3:0] OUT_CHARACTER_VIDEO_RAM_OWNER = 4'h0;
  localparam logic [3:0] OUT_CTRL_EN = 4'h1;
  localparam logic [3:0] OUT_PIC_EN = 4'h2;
  localparam logic [3:0] OUT_SOUND_EN = 4'h3;
  localparam logic [3:0] OUT_GCPU_RST = 4'h4;
  localparam logic [3:0] OUT_GCPU_RUN = 4'h5;
  localparam logic [3:0] OUT_MON_SEL = 4'h6;
  localparam logic [3:0] OUT_NMI_EN = 4'h8;
  localparam logic [3:0] OUT_WDOG = 4'h9;
  localparam logic [3:0] OUT_PIC_RST = 4'hA;
  localparam logic [3:0] OUT_SLOT_LSB = 4'hB;
  localparam logic [3:0] OUT_BRAM_HI = 4'hF;
  localparam logic [15:0] OUT_PORTS_RESET = 16'h0000;

  // read ports
  localparam logic [7:0] IN_BUTTONS = 8'h00;
  localparam logic [7:0] IN_DIP1 = 8'h01;
  localparam logic [7:0] IN_DIP2 = 8'h02;
  localparam logic [7:0] IN_IRQ_CLR = 8'h03;
  localparam logic [7:0] IN_UNMAPPED = 8'h00;

  // memory map bases and sizes
  localparam logic [15:0] MEM_BOOT_BASE = 16'h0000;
  localparam logic [15:0] MEM_BOOT_SIZE = 16'h4000;
  localparam logic [15:0] MEM_WRAM_BASE = 16'h8000;
  localparam logic [15:0] MEM_BRAM_BASE = 16'h8800;
  localparam logic [15:0] MEM_BRAM_HI_BASE = 16'h8C00;
  localparam logic [15:0] MEM_CHARACTER_VIDEO_RAM_BASE = 16'h9000;
  localparam logic [15:0] MEM_2K_SIZE = 16'h0800;
  localparam logic [15:0] MEM_1K_SIZE = 16'h0400;
  localparam logic [15:0] MEM_CART_BASE = 16'hC000;
  localparam logic [15:0] MEM_PROT_BASE = 16'hE000;
  localparam logic [15:0] MEM_8K_SIZE = 16'h2000;

  localparam logic [3:0] SLOT_COUNT = 4'hA;
  localparam logic [3:0] WD_FRAMES = 4'h8;

  typedef enum logic [0:0] {
    WD_WATCH = 1'b0,
    WD_FIRE = 1'b1
  } acv_wd_type;

  // address window hit, size a power of two
  function automatic logic addrHit(input logic [15:0] a, input logic [15:0] base,
                                   input logic [15:0] size);
    addrHit = ((a & ~(size - 16'h0001)) == base);
  endfunction : addrHit

endpackage : acv_pkg

// ==== sim/acv_control_checker.sv ====
// port-level checks for acv_control
// assumes one clock domain, async active-low reset
`timescale 1ns/10ps
module acv_control_checker #(
  parameter int FRAME_CYCLES = 2096
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic [7:0] dipBank2,
  input wire logic vramSel,
  input wire logic cartBiosSel,
  input wire logic protectSel,
  input wire logic [3:0] slotNumber,
  input wire logic gameCpuResetN,
  input wire logic gameCpuRun,
  input wire logic monitorGameSel,
  input wire logic cpuNmi,
  input wire logic cpuResetN
);
  logic [15:0] wr;
  int sinceNmi;
  assign wr = (ce && ioWr && ioAddr[7:4] == 4'h0) ? 16'h0001 << ioAddr[3:0] : 16'h0000;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sinceNmi <= 0;
    else if (cpuNmi) sinceNmi <= 1;
    else if (ce && sinceNmi > 0) sinceNmi <= sinceNmi + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  cpu_reset_a: assert property (wr[4] |=> gameCpuResetN == $past(ioWrData[0]))
    else $error("game cpu reset latch wrong");
  cpu_run_a: assert property (wr[5] |=> gameCpuRun == $past(ioWrData[0]))
    else $error("game cpu run latch wrong");
  mon_hold_a: assert property (!wr[6] |=> $stable(monitorGameSel))
    else $error("monitor select moved without write");
  zero_bits_a: assert property (ce && ioRd && ioAddr == 8'h00
      |=> !ioRdData[4] && !ioRdData[7])
    else $error("port 0 fixed bits not zero");
  dip_read_a: assert property (ce && ioRd && ioAddr == 8'h02 && $past(resetn, 3)
      && $stable(dipBank2) && $past(dipBank2, 2) == dipBank2 |=> ioRdData == $past(dipBank2))
    else $error("dip bank read wrong");
  character_video_ram_dec_a: assert property (vramSel |-> memAddr[15:11] == 5'h12)
    else $error("video ram select outside window");
  slot_dec_a: assert property (cartBiosSel || protectSel |-> slotNumber < 4'hA)
    else $error("cart select with bad slot");
  nmi_pulse_a: assert property (cpuNmi |=> !cpuNmi)
    else $error("nmi longer than one cycle");
  nmi_period_a: assert property (cpuNmi && sinceNmi > 0 |-> sinceNmi % FRAME_CYCLES == 0)
    else $error("nmi off frame spacing");
  wd_hold_a: assert property ($fell(cpuResetN) |=> !cpuResetN ##98 !cpuResetN ##1 cpuResetN)
    else $error("watchdog reset hold wrong");
endmodule : acv_control_checker
bind acv_control acv_control_checker #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (.clk, .resetn, .ce,
  .memAddr, .ioAddr, .ioRd, .ioWr, .ioWrData, .ioRdData, .dipBank2, .vramSel, .cartBiosSel,
  .protectSel, .slotNumber, .gameCpuResetN, .gameCpuRun, .monitorGameSel, .cpuNmi, .cpuResetN);

// ==== sim/acv_game_side.sv ====
// game part model: pulls its interrupt line low on request
// assumes fire is sampled on clk
`timescale 1ns/10ps
module acv_game_side #(
  parameter int LOW_CYCLES = 4
) (
  input wire logic clk,
  input wire logic fire,
  output logic gameIrqN
);
  int cnt = 0;
  always @(posedge clk) begin
    if (fire) cnt <= LOW_CYCLES;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign gameIrqN = (cnt == 0);
endmodule : acv_game_side

// ==== sim/tb_acv_control.sv ====
// self-checking bench for acv_control
// assumes acv_game_side stands in for the game part
`timescale 1ns/10ps
module tb_acv_control;
  import acv_pkg::*;
  localparam int FC = 2096;
  logic clk, resetn, ce, memWr, ioRd, ioWr, fire;
  logic [15:0] memAddr;
  logic [7:0] memWrData, ioAddr, ioWrData, dip1, dip2, v0, v1;
  logic [4:0] btn;
  wire [7:0] ioRdData;
  wire [5:0] sel;
  wire [6:0] ctl;
  wire [3:0] slotNumber;
  wire [10:0] charCode;
  wire [4:0] charColor;
  wire [2:0] pixX, pixY;
  wire irqN, nmi, cpuResetN, pixValid;
  logic sh [16];
  logic [15:0] corner [10] = '{16'h3FFF, 16'h4000, 16'h87FF, 16'h8800, 16'h8BFF, 16'h8C00,
    16'h97FF, 16'h9800, 16'hBFFF, 16'hE000};
  int num_errors = 0;
  int total_checks = 0;
  int n;
  acv_game_side i_game (.clk(clk), .fire(fire), .gameIrqN(irqN));
  acv_control #(.FRAME_CYCLES(FC)) i_dut (.clk(clk), .resetn(resetn), .ce(ce),
    .memAddr(memAddr), .memWr(memWr), .memWrData(memWrData), .ioAddr(ioAddr), .ioRd(ioRd),
    .ioWr(ioWr), .ioWrData(ioWrData), .ioRdData(ioRdData), .btnSelect(btn[0]),
    .btnEnter(btn[1]), .btnReset(btn[2]), .coin2(btn[3]), .btnService(btn[4]),
    .dipBank1(dip1), .dipBank2(dip2), .gameIrqN(irqN), .bootRomSel(sel[5]),
    .workRamSel(sel[4]), .backupRamSel(sel[3]), .vramSel(sel[2]), .cartBiosSel(sel[1]),
    .protectSel(sel[0]), .slotNumber(slotNumber), .controlsEnable(ctl[6]),
    .pictureOutEnable(ctl[5]), .soundOutEnable(ctl[4]), .gameCpuResetN(ctl[3]),
    .gameCpuRun(ctl[2]), .monitorGameSel(ctl[1]), .pictureResetN(ctl[0]), .cpuNmi(nmi),
    .cpuResetN(cpuResetN), .pixValid(pixValid), .pixX(pixX), .pixY(pixY), .charCode(charCode),
    .charColor(charColor));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic iow(input logic [7:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWr = 1'b1;
    cyc(1);
    ioWr = 1'b0;
    cyc(1);
    if (a[7:4] == 4'h0) sh[a[3:0]] = d[0];
  endtask : iow
  task automatic ior(input logic [7:0] a, input logic [7:0] exp);
    ioAddr = a;
    ioRd = 1'b1;
    cyc(1);
    ioRd = 1'b0;
    cyc(1);
    chk("ioRdData", ioRdData, exp);
  endtask : ior
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    memAddr = a;
    memWrData = d;
    memWr = 1'b1;
    cyc(1);
    memWr = 1'b0;
    cyc(1);
  endtask : mw
  function automatic logic [5:0] dec(input logic [15:0] a);
    logic ok;
    ok = {sh[14], sh[13], sh[12], sh[11]} < 4'hA;
    dec = {a[15:14] == 2'h0, a[15:11] == 5'h10, a[15:11] == 5'h11 && (!a[10] || sh[15]),
      a[15:11] == 5'h12 && !sh[0], a[15:13] == 3'h6 && ok, a[15:13] == 3'h7 && ok};
  endfunction : dec
  function automatic logic [7:0] p0(input logic f);
    p0 = {1'b0, btn[4], btn[3], 1'b0, f, btn[2:0]};
  endfunction : p0
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic count(input int k, input int which);
    n = 0;
    repeat (k) begin
      cyc(1);
      n += (which == 0) ? int'(nmi) : (which == 1) ? int'(pixValid) : int'(!cpuResetN);
    end
  endtask : count
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #800000;
    num_errors++;
    stop_test();
  end
  initial begin
    {resetn, memWr, ioRd, ioWr, fire, memAddr, memWrData, ioAddr, ioWrData} = '0;
    {dip1, dip2, btn} = '0;
    ce = 1'b1;
    foreach (sh[i]) sh[i] = 1'b0;
    n = $urandom(32);
    cyc(2);
    resetn = 1'b1;
    chk("ctl", ctl, 7'h00);
    chk("cpuResetN", cpuResetN, 1'b1);
    ce = 1'b0;
    iow(8'h01, 8'h01);
    sh[1] = 1'b0;
    chk("ceHold", ctl, 7'h00);
    ce = 1'b1;
    for (int i = 0; i < 60; i++) begin
      memAddr = (i < 10) ? corner[i] : 16'($urandom);
      iow(8'($urandom_range(0, 31)), 8'($urandom));
      chk("ctl", ctl, {sh[1], sh[2], sh[3], sh[4], sh[5], sh[6], sh[10]});
      chk("slot", slotNumber, {sh[14], sh[13], sh[12], sh[11]});
      chk("sel", sel, dec(memAddr));
    end
    for (int i = 0; i < 6; i++) begin
      dip1 = 8'($urandom);
      dip2 = 8'($urandom);
      btn = (i == 0) ? 5'h1F : 5'($urandom);
      cyc(3);
      ior(8'h00, p0(1'b0));
      ior(8'h01, dip1);
      ior(8'h02, dip2);
      ior(8'($urandom_range(4, 255)), 8'h00);
    end
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(8);
    ior(8'h00, p0(1'b1));
    ior(8'h00, p0(1'b1));
    ior(8'h03, 8'h00);
    ior(8'h00, p0(1'b0));
    v0 = 8'($urandom);
    v1 = 8'($urandom);
    iow(8'h00, 8'h00);
    iow(8'h08, 8'h01);
    mw(16'h9000, ~v0);
    mw(16'h9080, v0);
    mw(16'h9081, v1);
    iow(8'h00, 8'h01);
    mw(16'h9080, ~v0);
    n = 0;
    while (nmi !== 1'b1 && n < 2 * FC) begin
      cyc(1);
      n++;
    end
    count(FC, 0);
    chk("nmiCount", 16'(n), 16'h0001);
    while (pixValid !== 1'b1 && n < FC) begin
      cyc(1);
      n++;
    end
    chk("charCode", charCode, {v1[2:0], v0});
    chk("charColor", charColor, v1[7:3]);
    chk("pixXY", {pixY, pixX}, 6'h00);
    iow(8'h00, 8'h00);
    iow(8'h08, 8'h00);
    count(FC, 1);
    chk("pixBlank", 16'(n), 16'h0000);
    count(FC, 0);
    chk("nmiOff", 16'(n), 16'h0000);
    iow(8'h09, 8'h01);
    cyc(110);
    iow(8'h09, 8'h00);
    iow(8'h09, 8'h01);
    iow(8'h09, 8'h00);
    n = 0;
    while (cpuResetN === 1'b1 && n < 9 * FC) begin
      cyc(1);
      n++;
    end
    chk("wdFire", 16'(n > 7 * FC - 8 && n <= 8 * FC), 16'h0001);
    cyc(110);
    iow(8'h09, 8'h01);
    count(9 * FC, 2);
    chk("wdOff", 16'(n), 16'h0000);
    stop_test();
  end
endmodule : tb_acv_control
